// ### bench/adcsq_host_model.sv
`default_nettype none
module adcsq_host_model (
  input wire logic i_mclk,
  input wire logic i_sdo,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // sclk stands low outside frames; 200 ns period, four mclk per phase
  // s takes serial_out at the rising edge; this pacing bounds the host's sample rate
  task automatic bit_out(input logic b, output logic s);
    @(posedge i_mclk) o_din <= b;
    tick(1);
    s = i_sdo;
    o_sclk <= 1'b1;
    tick(4);
    o_sclk <= 1'b0;
    tick(2);
  endtask
  task automatic zeros(input int n);
    logic s;
    repeat (n) bit_out(1'b0, s);
  endtask
  task automatic send(input logic [7:0] cb, input int nz);
    logic s;
    @(posedge i_mclk) o_cs_n <= 1'b0;
    tick(4);
    zeros(nz);
    for (int i = 7; i >= 0; i--) bit_out(cb[i], s);
  endtask
  task automatic deselect;
    @(posedge i_mclk) o_cs_n <= 1'b1;
    tick(4);
  endtask
  // last pulse closes the frame count
  task automatic read16(output logic [15:0] v, input logic ci);
    logic b;
    if (ci) begin
      @(posedge i_mclk) o_cs_n <= 1'b0;
      tick(8);
    end else begin
      tick(4);
    end
    for (int i = 0; i < 16; i++) begin
      bit_out(1'b0, b);
      v = {v[14:0], b};
    end
    deselect();
  endtask
endmodule
`default_nettype wire

// ### bench/adcsq_top_bench.sv
`default_nettype none
`include "adcsq_regs.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module adcsq_top_bench
  import adcsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_n = 1'b0, shutdown_pin_n = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sdo, sdo_oe, strb, strb_oe, cs_n, sclk, din;
  logic [2:0] aux;
  logic last_uni = 1'b0, last_long = 1'b0;
  int errors = 0, check_count = 0, seed = 32'hB0C2;
  always #12.5 mclk = ~mclk;
  adcsq_top #(.P_CAL_CYCLES(20)) i_dut (.i_mclk(mclk), .i_reset_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_din(din), .i_shutdown_pin_n(shutdown_pin_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_serial_out(sdo), .o_serial_out_oe(sdo_oe), .o_conversion_strobe(strb),
    .o_conversion_strobe_oe(strb_oe), .o_aux_out(aux));
  adcsq_host_model i_host (.i_mclk(mclk), .i_sdo(sdo_oe ? sdo : ~sdo), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_strb;
    int n;
    n = 0;
    while (strb !== 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    `CHK(n < 400, 1'b1)
  endtask
  task automatic conv(input logic uni, input logic ci, input logic [1:0] m);
    logic [31:0] r;
    logic e, lng;
    logic [15:0] s, got;
    logic [2:0] ax;
    s = $random(seed);
    ax = $random(seed);
    lng = (m == 2'h2) ? last_long : (m == 2'h3);
    apb(1'b1, `ADCSQ_ADDR_SAMPLE, {16'h0, s}, r, e);
    i_host.send({1'b1, uni, ci, m, ax}, $unsigned($random(seed)) % 4);
    if (lng) i_host.zeros(8);
    if (ci) begin
      i_host.deselect();
      wait_strb();
    end
    i_host.read16(got, ci);
    `CHK(got, uni ? s : s ^ 16'h8000)
    `CHK(aux, ax)
    apb(1'b0, `ADCSQ_ADDR_STATUS, 32'h0, r, e);
    `CHK(r[6:0], {m == 2'h2, lng, ci, uni, 3'h0})
    `CHK(r[13:9], (lng ? 5'h1A : 5'h0A) - (uni != last_uni ? 5'h03 : 5'h00))
    last_uni = uni;
    last_long = lng;
  endtask
  initial begin
    logic [31:0] r;
    logic e, uni, ci;
    logic [1:0] m;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    apb(1'b0, `ADCSQ_ADDR_STATUS, 32'h0, r, e);
    `CHK(r[7:0], 8'h10)
    `CHK({aux, strb}, 4'h1)
    apb(1'b0, `ADCSQ_ADDR_SAMPLE, 32'h0, r, e);
    `CHK(r, 32'h0000_8000)
    apb(1'b0, 12'h00C, 32'h0, r, e);
    `CHK({e, r}, 33'h1_0000_0000)
    i_host.send(8'h00, 3);
    apb(1'b0, `ADCSQ_ADDR_STATUS, 32'h0, r, e);
    `CHK(r[2:0], 3'h0)
    i_host.deselect();
    i_host.send(8'hA8, 1);
    i_host.deselect();
    `CHK(strb, 1'b0)
    wait_strb();
    apb(1'b0, `ADCSQ_ADDR_STATUS, 32'h0, r, e);
    `CHK(r[7], 1'b1)
    i_host.send(8'h88, 0);
    `CHK(strb, 1'b1)
    i_host.zeros(22);
    `CHK(strb, 1'b0)
    i_host.deselect();
    i_host.send(8'hA8, 0);
    i_host.deselect();
    conv(1'b1, 1'b1, 2'h0);
    i_host.send(8'hA8, 0);
    i_host.deselect();
    shutdown_pin_n <= 1'b0;
    repeat (4) @(posedge mclk);
    shutdown_pin_n <= 1'b1;
    apb(1'b0, `ADCSQ_ADDR_STATUS, 32'h0, r, e);
    `CHK({r[6], r[2:0]}, 4'h8)
    last_uni = 1'b0;
    for (int i = 0; i < 10; i++) begin
      uni = $random(seed);
      ci = $random(seed);
      m = $random(seed);
      if (m == 2'h1) m = 2'h0;
      conv(uni, ci, m);
    end
    end_sim();
  end
  initial begin
    #1000000;
    errors++;
    end_sim();
  end
endmodule
bind adcsq_top adcsq_top_sva #(.P_CAL_CYCLES(P_CAL_CYCLES)) i_sva (.i_mclk, .i_reset_n, .i_cs_n, .i_psel,
  .i_penable, .i_paddr, .o_prdata, .o_pready, .o_pslverr, .o_serial_out_oe, .o_conversion_strobe,
  .o_conversion_strobe_oe, .o_aux_out);
`default_nettype wire

// ### bench/adcsq_top_sva.sv
`default_nettype none
module adcsq_top_sva #(
  parameter int unsigned P_CAL_CYCLES = 20
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_cs_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_serial_out_oe,
  input wire logic o_conversion_strobe,
  input wire logic o_conversion_strobe_oe,
  input wire logic [2:0] o_aux_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  int unsigned low_cnt_r;
  // span of internal-mode strobe low while deselected
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_cnt_r <= 0;
    end else if (o_conversion_strobe_oe && i_cs_n && !o_conversion_strobe) begin
      low_cnt_r <= low_cnt_r + 1;
    end else begin
      low_cnt_r <= 0;
    end
  end
  property p_ready_next; i_psel && !i_penable |=> o_pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready late");
  property p_ready_pulse; o_pready |=> !o_pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_err_map;
    i_psel && !i_penable && !(i_paddr inside {12'h000, 12'h004, 12'h008}) |=> o_pslverr && o_prdata == 32'h0;
  endproperty
  a_err_map: assert property (p_err_map) else $error("no error on unmapped");
  property p_ok_map; i_psel && !i_penable && i_paddr inside {12'h000, 12'h004, 12'h008} |=> !o_pslverr; endproperty
  a_ok_map: assert property (p_ok_map) else $error("error on mapped");
  property p_out_hiz; i_cs_n [*6] |-> !o_serial_out_oe; endproperty
  a_out_hiz: assert property (p_out_hiz) else $error("output driven deselected");
  property p_out_drive; !i_cs_n [*6] |-> o_serial_out_oe && o_conversion_strobe_oe; endproperty
  a_out_drive: assert property (p_out_drive) else $error("output not driven");
  property p_reset_dflt; $rose(i_reset_n) |-> o_aux_out == 3'h0 && o_conversion_strobe && o_conversion_strobe_oe;
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) else $error("bad reset state");
  property p_aux_cs; $changed(o_aux_out) |-> !$past(i_cs_n, 4); endproperty
  a_aux_cs: assert property (p_aux_cs) else $error("aux moved deselected");
  property p_strobe_low; low_cnt_r < 4 * P_CAL_CYCLES + 100; endproperty
  a_strobe_low: assert property (p_strobe_low) else $error("strobe low too long");
  c_err: cover property ($rose(o_pslverr));
  c_strobe: cover property ($fell(o_conversion_strobe));
  c_aux: cover property ($changed(o_aux_out));
endmodule
`default_nettype wire

// ### design/adcsq_pkg.sv
`default_nettype none

package adcsq_pkg;

  typedef enum logic [2:0] {
    ADCSQ_IDLE     = 3'b000,
    ADCSQ_ACQ      = 3'b001,
    ADCSQ_CONV_EXT = 3'b010,
    ADCSQ_CONV_INT = 3'b011,
    ADCSQ_CAL      = 3'b100
  } adcsq_state_e;

  typedef logic [15:0] adcsq_result_t;

endpackage

`default_nettype wire

// ### design/adcsq_regs.svh
`ifndef ADCSQ_REGS_SVH
`define ADCSQ_REGS_SVH

// apb register byte addresses
`define ADCSQ_ADDR_STATUS 12'h000
`define ADCSQ_ADDR_SAMPLE 12'h004
`define ADCSQ_ADDR_CTRLBYTE 12'h008
`define ADCSQ_SAMPLE_RST 16'h8000

// control byte bit positions, start bit first on the wire
`define ADCSQ_CB_RANGE 6
`define ADCSQ_CB_CLK 5
`define ADCSQ_CB_M1 4
`define ADCSQ_CB_M0 3
`define ADCSQ_CB_AUX_MSB 2

// field encodings
`define ADCSQ_MODE_SHORT 2'h0
`define ADCSQ_MODE_CAL 2'h1
`define ADCSQ_MODE_PDOWN 2'h2
`define ADCSQ_MODE_LONG 2'h3
`define ADCSQ_RANGE_BIPOLAR 1'h0
`define ADCSQ_CLK_INTERNAL 1'h1
`define ADCSQ_AUX_RST 3'h0

// serial clock counts
`define ADCSQ_BIT_START 4'h1
`define ADCSQ_BIT_RANGE 4'h1
`define ADCSQ_BIT_CONV 4'h7
`define ADCSQ_BIT_LAST 4'h8
`define ADCSQ_FALL_SHORT 6'h07
`define ADCSQ_FALL_LONG 6'h0F
`define ADCSQ_TOTAL_SHORT 6'h18
`define ADCSQ_TOTAL_LONG 6'h20
`define ADCSQ_ACQ_SHORT 5'h05
`define ADCSQ_ACQ_EXTRA 5'h08
`define ADCSQ_RANGE_SW_HALF 5'h03

// internal conversion clock
`define ADCSQ_INT_DIV 3'h4
`define ADCSQ_CONV_INT_CYCLES 5'h12
`define ADCSQ_CAL_CYCLES 80000
`define ADCSQ_RESULT_BITS 5'h10

`endif

// ### design/adcsq_result_shift.sv
`default_nettype none
`include "adcsq_regs.svh"

module adcsq_result_shift
  import adcsq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_load,
  input wire adcsq_result_t i_data,
  input wire logic i_shift,
  output logic o_bit
);

  adcsq_result_t word_r;
  logic [4:0] left_r;

  // holds the result and presents it msb first, one bit per shift
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      word_r <= '0;
      left_r <= '0;
      o_bit <= 1'b0;
    end else if (i_load) begin
      word_r <= i_data;
      o_bit <= i_data[15];
      left_r <= `ADCSQ_RESULT_BITS - 5'h01;
    end else if (i_shift) begin
      word_r <= {word_r[14:0], 1'b0};
      if (left_r != 5'h00) begin
        o_bit <= word_r[14];
        left_r <= left_r - 5'h01;
      end else begin
        o_bit <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ### design/adcsq_top.sv
// Decided for this implementation: the register offsets and the APB interface to the registers.
`default_nettype none
`include "adcsq_regs.svh"

module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int unsigned P_CAL_CYCLES = `ADCSQ_CAL_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_din,
  input wire logic i_shutdown_pin_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_serial_out,
  output logic o_serial_out_oe,
  output logic o_conversion_strobe,
  output logic o_conversion_strobe_oe,
  output logic [2:0] o_aux_out
);

  function automatic adcsq_result_t fmt_result(input adcsq_result_t code, input logic range_uni);
    fmt_result = range_uni ? code : {~code[15], code[14:0]};
  endfunction

  function automatic logic [4:0] acq_half(input logic long_acq, input logic switched);
    logic [4:0] cyc;
    cyc = long_acq ? (`ADCSQ_ACQ_SHORT + `ADCSQ_ACQ_EXTRA) : `ADCSQ_ACQ_SHORT;
    acq_half = {cyc[3:0], 1'b0} - (switched ? `ADCSQ_RANGE_SW_HALF : 5'h00);
  endfunction

  // pin synchronisers
  logic [1:0] cs_sync_r, sclk_sync_r, din_sync_r, shutdown_pin_sync_r;
  logic cs_d_r, sclk_d_r;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cs_sync_r <= 2'h3;
      sclk_sync_r <= 2'h0;
      din_sync_r <= 2'h0;
      shutdown_pin_sync_r <= 2'h3;
      cs_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
    end else begin
      cs_sync_r <= {cs_sync_r[0], i_cs_n};
      sclk_sync_r <= {sclk_sync_r[0], i_sclk};
      din_sync_r <= {din_sync_r[0], i_din};
      shutdown_pin_sync_r <= {shutdown_pin_sync_r[0], i_shutdown_pin_n};
      cs_d_r <= cs_sync_r[1];
      sclk_d_r <= sclk_sync_r[1];
    end
  end

  logic cs_n, din, shutdown_pin_ok, cs_fall, rise_en, fall_en;
  assign cs_n = cs_sync_r[1];
  assign din = din_sync_r[1];
  assign shutdown_pin_ok = shutdown_pin_sync_r[1];
  assign cs_fall = !cs_n && cs_d_r;
  assign rise_en = sclk_sync_r[1] && !sclk_d_r && !cs_n;
  assign fall_en = !sclk_sync_r[1] && sclk_d_r && !cs_n;

  // internal conversion clock as an enable
  logic [2:0] div_cnt_r;
  logic int_tick;
  assign int_tick = (div_cnt_r == `ADCSQ_INT_DIV - 3'h1);

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_cnt_r <= 3'h0;
    end else begin
      div_cnt_r <= int_tick ? 3'h0 : div_cnt_r + 3'h1;
    end
  end

  adcsq_state_e state_r;
  logic [7:0] ctrl_sr_r, ctrl_byte_r;
  logic [3:0] bit_cnt_r;
  logic arm_r, collecting, start_ok;

  assign collecting = (bit_cnt_r != 4'h0) && (bit_cnt_r != `ADCSQ_BIT_LAST);
  // a start needs a one on serial_in, never a select edge alone
  assign start_ok = rise_en && din && shutdown_pin_ok &&
                    (arm_r || (state_r == ADCSQ_IDLE && !collecting));

  // a select high-low pulse re-arms start detection
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      arm_r <= 1'b0;
    end else if (start_ok) begin
      arm_r <= 1'b0;
    end else if (cs_fall) begin
      arm_r <= 1'b1;
    end
  end

  // control byte shift in, start bit lands in the msb
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_sr_r <= 8'h00;
      bit_cnt_r <= 4'h0;
    end else if (start_ok) begin
      ctrl_sr_r <= 8'h01;
      bit_cnt_r <= `ADCSQ_BIT_START;
    end else if (rise_en && collecting) begin
      ctrl_sr_r <= {ctrl_sr_r[6:0], din};
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // aux outputs take the byte's low three bits once its last bit is in
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_aux_out <= `ADCSQ_AUX_RST;
      ctrl_byte_r <= 8'h00;
    end else if (rise_en && bit_cnt_r == `ADCSQ_BIT_CONV) begin
      o_aux_out <= {ctrl_sr_r[1:0], din};
      ctrl_byte_r <= {ctrl_sr_r[6:0], din};
    end
  end

  // range switches on the second bit, before the byte completes
  logic range_r, range_sw_r;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      range_r <= `ADCSQ_RANGE_BIPOLAR;
      range_sw_r <= 1'b0;
    end else if (rise_en && collecting && bit_cnt_r == `ADCSQ_BIT_RANGE) begin
      range_r <= din;
      range_sw_r <= (din != range_r);
    end
  end

  // decode of the first seven bits at the seventh falling edge, the short-mode conversion start
  logic [7:0] partial;
  logic [1:0] dec_mode;
  logic [5:0] fcnt_r, fnext;
  logic at_conv_bit, clk_now, long_now, conv_now;
  logic clk_int_r, long_r, pd_req_r, pdown_r, cal_valid_r, strobe_r;
  logic [5:0] conv_fall;
  logic [16:0] cal_cnt_r;
  logic [4:0] conv_cnt_r, acq_half_r;
  logic cal_last, res_load, res_shift;
  adcsq_result_t sample_r, sample_hold_r;

  assign partial = {ctrl_sr_r[6:0], 1'b0};
  assign dec_mode = {partial[`ADCSQ_CB_M1], partial[`ADCSQ_CB_M0]};
  assign fnext = fcnt_r + 6'h01;
  assign at_conv_bit = (fnext == `ADCSQ_FALL_SHORT) && (bit_cnt_r >= `ADCSQ_BIT_CONV);
  assign clk_now = at_conv_bit ? partial[`ADCSQ_CB_CLK] : clk_int_r;
  // shutdown mode keeps the previous acquisition length
  assign long_now = at_conv_bit ? (dec_mode == `ADCSQ_MODE_LONG ||
                    (dec_mode == `ADCSQ_MODE_PDOWN && long_r)) : long_r;
  assign conv_fall = long_now ? `ADCSQ_FALL_LONG : `ADCSQ_FALL_SHORT;
  assign conv_now = fall_en && fnext == conv_fall &&
                    !(at_conv_bit && dec_mode == `ADCSQ_MODE_CAL);
  assign cal_last = (cal_cnt_r == 17'(P_CAL_CYCLES - 1));
  assign res_load = (state_r == ADCSQ_CONV_EXT && fall_en && fnext == conv_fall + 6'h01) ||
                    (state_r == ADCSQ_CONV_INT && int_tick &&
                     conv_cnt_r == `ADCSQ_CONV_INT_CYCLES - 5'h01);
  assign res_shift = fall_en && !res_load;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= ADCSQ_IDLE;
      fcnt_r <= 6'h00;
      clk_int_r <= `ADCSQ_CLK_INTERNAL;
      long_r <= 1'b0;
      pd_req_r <= 1'b0;
      pdown_r <= 1'b0;
      cal_valid_r <= 1'b0;
      strobe_r <= 1'b1;
      cal_cnt_r <= 17'h00000;
      conv_cnt_r <= 5'h00;
      acq_half_r <= 5'h00;
      sample_hold_r <= `ADCSQ_SAMPLE_RST;
    end else if (!shutdown_pin_ok) begin
      state_r <= ADCSQ_IDLE;
      pdown_r <= 1'b1;
      strobe_r <= clk_int_r;
    end else if (start_ok) begin
      state_r <= ADCSQ_ACQ;
      fcnt_r <= 6'h00;
      pdown_r <= 1'b0;
      strobe_r <= clk_int_r;
    end else begin
      case (state_r)
        ADCSQ_ACQ: begin
          if (fall_en) begin
            fcnt_r <= fnext;
            if (at_conv_bit) begin
              clk_int_r <= clk_now;
              if (dec_mode == `ADCSQ_MODE_CAL) begin
                state_r <= ADCSQ_CAL;
                cal_cnt_r <= 17'h00000;
                strobe_r <= !clk_now;
              end else begin
                long_r <= long_now;
                pd_req_r <= (dec_mode == `ADCSQ_MODE_PDOWN);
                acq_half_r <= acq_half(long_now, range_sw_r);
              end
            end
            if (conv_now) begin
              sample_hold_r <= sample_r;
              conv_cnt_r <= 5'h00;
              state_r <= clk_now ? ADCSQ_CONV_INT : ADCSQ_CONV_EXT;
              strobe_r <= !clk_now;
            end
          end
        end
        ADCSQ_CONV_EXT: begin
          if (fall_en) begin
            fcnt_r <= fnext;
            strobe_r <= 1'b0;
            if (fnext == (long_r ? `ADCSQ_TOTAL_LONG : `ADCSQ_TOTAL_SHORT)) begin
              state_r <= ADCSQ_IDLE;
              pdown_r <= pd_req_r;
            end
          end
        end
        ADCSQ_CONV_INT: begin
          if (int_tick) begin
            conv_cnt_r <= conv_cnt_r + 5'h01;
            if (res_load) begin
              strobe_r <= 1'b1;
              state_r <= ADCSQ_IDLE;
              pdown_r <= pd_req_r;
            end
          end
        end
        ADCSQ_CAL: begin
          if (clk_int_r ? int_tick : fall_en) begin
            cal_cnt_r <= cal_cnt_r + 17'h00001;
            if (cal_last) begin
              state_r <= ADCSQ_IDLE;
              strobe_r <= clk_int_r;
              cal_valid_r <= 1'b1;
            end
          end
        end
        default: begin
          state_r <= ADCSQ_IDLE;
        end
      endcase
    end
  end

  adcsq_result_shift u_result (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_load(res_load),
    .i_data(fmt_result(sample_hold_r, range_r)),
    .i_shift(res_shift),
    .o_bit(o_serial_out)
  );

  // external mode strobe floats while deselected
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_serial_out_oe <= 1'b0;
      o_conversion_strobe_oe <= 1'b1;
      o_conversion_strobe <= 1'b1;
    end else begin
      o_serial_out_oe <= !cs_n;
      o_conversion_strobe_oe <= clk_int_r || !cs_n;
      o_conversion_strobe <= strobe_r;
    end
  end

  // apb slave, no wait states, answer registered at the setup cycle
  logic setup, mapped;
  assign setup = i_psel && !i_penable;
  assign mapped = (i_paddr == `ADCSQ_ADDR_STATUS) || (i_paddr == `ADCSQ_ADDR_SAMPLE) ||
                  (i_paddr == `ADCSQ_ADDR_CTRLBYTE);

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end else begin
      o_pready <= setup && !o_pready;
      o_pslverr <= setup && !mapped;
      if (setup) begin
        if (i_pwrite || !mapped) begin
          o_prdata <= 32'h00000000;
        end else if (i_paddr == `ADCSQ_ADDR_SAMPLE) begin
          o_prdata <= {16'h0000, sample_r};
        end else if (i_paddr == `ADCSQ_ADDR_CTRLBYTE) begin
          o_prdata <= {24'h000000, ctrl_byte_r};
        end else begin
          o_prdata <= {18'h00000, acq_half_r, arm_r, cal_valid_r, pdown_r, long_r, clk_int_r,
                       range_r, state_r};
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sample_r <= `ADCSQ_SAMPLE_RST;
    end else if (i_psel && i_penable && o_pready && i_pwrite &&
                 i_paddr == `ADCSQ_ADDR_SAMPLE) begin
      sample_r <= i_pwdata[15:0];
    end
  end

endmodule

`default_nettype wire
